// *** design/dmasc_channel.sv ***
// Single DMA channel with event pacing, register file and completion signalling.
`include "dmasc_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module dmasc_channel
    import dmasc_pkg::*;
#(
    parameter int ADDR_W = 24,
    parameter int DATA_W = 32
) (
    input  wire logic              ref_clk,
    input  wire logic              rst,
    // Peripheral bus register port.
    input  wire logic [ADDR_W-1:0] pbus_addr,
    input  wire logic              pbus_wr,
    input  wire logic              pbus_rd,
    input  wire logic [DATA_W-1:0] pbus_wdata,
    output logic      [DATA_W-1:0] pbus_rdata,
    // DMA memory access port.
    output logic                   dma_req,
    output logic                   dma_we,
    output logic      [ADDR_W-1:0] dma_addr,
    output logic      [DATA_W-1:0] dma_wdata,
    output logic                   dma_shared_port,
    input  wire logic              dma_ack,
    input  wire logic [DATA_W-1:0] dma_rdata,
    input  wire logic              cpu_shared_port_busy,
    // Serial pacing events and their routing enables.
    input  wire logic              serial_rx_event,
    input  wire logic              serial_tx_buffer_empty,
    input  wire logic              rx_route_en,
    input  wire logic              tx_route_en,
    // Completion signalling toward the CPU.
    output logic                   dma_done_flag,
    output logic                   dma_irq_req
);

    dmasc_state_t      state;
    logic [DATA_W-1:0] dma_global_control;
    logic [DATA_W-1:0] dma_source_address;
    logic [DATA_W-1:0] dma_destination_address;
    logic [DATA_W-1:0] dma_transfer_counter;
    logic [DATA_W-1:0] data_hold;
    logic [1:0]        start_field;
    logic [1:0]        sync_mode;
    logic              count_zero_halt;
    logic              count_zero_irq_enable;
    logic              event_pending;
    logic              serial_tx_event;
    logic              ctrl_wr;
    logic              src_wr;
    logic              dst_wr;
    logic              cnt_wr;
    logic              running;
    logic              read_needs_event;
    logic              write_needs_event;
    logic              need_event;
    logic              port_blocked;
    logic              launch;
    logic              read_done;
    logic              write_done;
    logic              block_end;
    logic              consume;
    logic              flush;
    logic [DATA_W-1:0] next_count;
    logic [ADDR_W-1:0] next_addr;
    logic              next_shared;

    // ==================================================================
    // Register decode.
    assign ctrl_wr = pbus_wr && (pbus_addr == `DMASC_GLOBAL_CONTROL_ADDR);
    assign src_wr  = pbus_wr && (pbus_addr == `DMASC_GLOBAL_CONTROL_ADDR + `DMASC_SRC_OFFSET);
    assign dst_wr  = pbus_wr && (pbus_addr == `DMASC_GLOBAL_CONTROL_ADDR + `DMASC_DST_OFFSET);
    assign cnt_wr  = pbus_wr && (pbus_addr == `DMASC_GLOBAL_CONTROL_ADDR + `DMASC_COUNT_OFFSET);

    assign start_field           = dma_global_control[`DMASC_START_LSB +: 2];
    assign sync_mode             = dma_global_control[`DMASC_SYNC_LSB +: 2];
    assign count_zero_halt       = dma_global_control[`DMASC_HALT_BIT];
    assign count_zero_irq_enable = dma_global_control[`DMASC_IRQ_EN_BIT];
    assign running               = (start_field == `DMASC_START_RUN);

    // ==================================================================
    // Pacing decisions.
    assign read_needs_event  = (sync_mode == `DMASC_SYNC_READ) || (sync_mode == `DMASC_SYNC_BOTH);
    assign write_needs_event = (sync_mode == `DMASC_SYNC_WRITE) || (sync_mode == `DMASC_SYNC_BOTH);
    assign need_event = (state == DMASC_READ) ? read_needs_event : write_needs_event;

    // The shared port carries both expansion and peripheral cycles, so the DMA
    // waits whenever the CPU owns it; judged on the address about to be used.
    assign port_blocked = next_shared && cpu_shared_port_busy;

    assign launch = running && !dma_req && (state != DMASC_HALT)
                    && (!need_event || event_pending) && !port_blocked;
    assign consume = launch && need_event;

    // With write-only pacing, events seen before the read finishes are dropped.
    assign flush = (sync_mode == `DMASC_SYNC_NONE)
                   || ((sync_mode == `DMASC_SYNC_WRITE) && (state != DMASC_WRITE));

    // A late CPU-side stall is honoured by holding the request until acknowledged.
    assign read_done  = dma_req && !dma_we && dma_ack;
    assign write_done = dma_req && dma_we && dma_ack;
    assign next_count = dma_transfer_counter - {{(DATA_W-1){1'b0}}, 1'b1};
    assign block_end  = write_done && count_zero_halt && (dma_transfer_counter == '0);

    dmasc_event_gen u_event_gen (
        .ref_clk                (ref_clk),
        .rst                    (rst),
        .serial_rx_event        (serial_rx_event),
        .serial_tx_buffer_empty (serial_tx_buffer_empty),
        .rx_route_en            (rx_route_en),
        .tx_route_en            (tx_route_en),
        .consume                (consume),
        .flush                  (flush),
        .serial_tx_event        (serial_tx_event),
        .event_pending          (event_pending)
    );

    // ==================================================================
    // Channel sequencer.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state <= DMASC_HALT;
        end else if (!running) begin
            state <= DMASC_HALT;
        end else begin
            unique case (state)
                DMASC_HALT: begin
                    state <= DMASC_READ;
                end
                DMASC_READ: begin
                    if (read_done) begin
                        state <= DMASC_WRITE;
                    end
                end
                DMASC_WRITE: begin
                    if (block_end) begin
                        state <= DMASC_HALT;
                    end else if (write_done) begin
                        state <= DMASC_READ;
                    end
                end
            endcase
        end
    end

    // ==================================================================
    // Memory access port; all outputs held in flops.
    assign next_addr = (state == DMASC_READ) ? dma_source_address[ADDR_W-1:0]
                                             : dma_destination_address[ADDR_W-1:0];
    assign next_shared = (next_addr[ADDR_W-1:12] == (ADDR_W-12)'(`DMASC_GLOBAL_CONTROL_ADDR >> 12));

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dma_req         <= 1'b0;
            dma_we          <= 1'b0;
            dma_addr        <= '0;
            dma_wdata       <= '0;
            dma_shared_port <= 1'b0;
        end else if (!running) begin
            dma_req <= 1'b0;
        end else if (launch) begin
            dma_req         <= 1'b1;
            dma_we          <= (state == DMASC_WRITE);
            dma_addr        <= next_addr;
            dma_wdata       <= data_hold;
            dma_shared_port <= next_shared;
        end else if (dma_ack) begin
            dma_req <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            data_hold <= `DMASC_WORD_RESET;
        end else if (read_done) begin
            data_hold <= dma_rdata;
        end
    end

    // ==================================================================
    // Control word; status bits mirror the sequencer, not software.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dma_global_control <= `DMASC_CTRL_RESET;
        end else if (ctrl_wr) begin
            dma_global_control <= pbus_wdata & `DMASC_CTRL_MASK;
        end else if (block_end) begin
            dma_global_control[`DMASC_START_LSB +: 2] <= 2'h0;
        end
    end

    // ==================================================================
    // Address and counter registers; a CPU write wins over a hardware update.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dma_source_address <= `DMASC_WORD_RESET;
        end else if (src_wr) begin
            dma_source_address <= pbus_wdata;
        end else if (read_done) begin
            if (dma_global_control[`DMASC_INC_SRC_BIT]) begin
                dma_source_address <= dma_source_address + 32'h00000001;
            end else if (dma_global_control[`DMASC_DEC_SRC_BIT]) begin
                dma_source_address <= dma_source_address - 32'h00000001;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dma_destination_address <= `DMASC_WORD_RESET;
        end else if (dst_wr) begin
            dma_destination_address <= pbus_wdata;
        end else if (write_done) begin
            if (dma_global_control[`DMASC_INC_DST_BIT]) begin
                dma_destination_address <= dma_destination_address + 32'h00000001;
            end else if (dma_global_control[`DMASC_DEC_DST_BIT]) begin
                dma_destination_address <= dma_destination_address - 32'h00000001;
            end
        end
    end

    // With the halt bit clear the counter simply wraps and transfers go on.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dma_transfer_counter <= `DMASC_WORD_RESET;
        end else if (cnt_wr) begin
            dma_transfer_counter <= pbus_wdata;
        end else if (read_done) begin
            dma_transfer_counter <= next_count;
        end
    end

    // ==================================================================
    // Completion pulses toward the CPU flag register and interrupt logic.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dma_done_flag <= 1'b0;
            dma_irq_req   <= 1'b0;
        end else begin
            dma_done_flag <= block_end && count_zero_irq_enable;
            dma_irq_req   <= block_end && count_zero_irq_enable;
        end
    end

    // ==================================================================
    // Register read-back, registered; unmapped addresses read zero.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pbus_rdata <= '0;
        end else if (pbus_rd) begin
            if (pbus_addr == `DMASC_GLOBAL_CONTROL_ADDR) begin
                pbus_rdata <= dma_global_control;
                pbus_rdata[`DMASC_STAT_LSB +: 2] <= (state == DMASC_HALT) ? `DMASC_STAT_HALTED
                                                                          : `DMASC_STAT_RUNNING;
            end else if (pbus_addr == `DMASC_GLOBAL_CONTROL_ADDR + `DMASC_SRC_OFFSET) begin
                pbus_rdata <= dma_source_address;
            end else if (pbus_addr == `DMASC_GLOBAL_CONTROL_ADDR + `DMASC_DST_OFFSET) begin
                pbus_rdata <= dma_destination_address;
            end else if (pbus_addr == `DMASC_GLOBAL_CONTROL_ADDR + `DMASC_COUNT_OFFSET) begin
                pbus_rdata <= dma_transfer_counter;
            end else begin
                pbus_rdata <= '0;
            end
        end
    end

endmodule // dmasc_channel

`default_nettype wire

// *** design/dmasc_regs.svh ***
// Register map, control-word fields and reset values of the synchronised DMA channel.
`ifndef DMASC_REGS_SVH
`define DMASC_REGS_SVH

// ==================================================================
// Register addresses (24-bit word addresses on the peripheral bus)
`define DMASC_GLOBAL_CONTROL_ADDR   24'h808000
`define DMASC_SRC_OFFSET            24'h000004
`define DMASC_DST_OFFSET            24'h000006
`define DMASC_COUNT_OFFSET          24'h000008
`define DMASC_SERIAL_TX_ADDR        24'h808048
`define DMASC_SERIAL_RX_ADDR        24'h80804C

// ==================================================================
// Global control word fields
`define DMASC_START_LSB             0
`define DMASC_STAT_LSB              2
`define DMASC_INC_SRC_BIT           4
`define DMASC_DEC_SRC_BIT           5
`define DMASC_INC_DST_BIT           6
`define DMASC_DEC_DST_BIT           7
`define DMASC_SYNC_LSB              8
`define DMASC_HALT_BIT              10
`define DMASC_IRQ_EN_BIT            11
`define DMASC_CTRL_MASK             32'h00000FF3

// ==================================================================
// Field values
`define DMASC_START_RUN             2'h3
`define DMASC_STAT_HALTED           2'h0
`define DMASC_STAT_RUNNING          2'h3
`define DMASC_SYNC_NONE             2'h0
`define DMASC_SYNC_READ             2'h1
`define DMASC_SYNC_WRITE            2'h2
`define DMASC_SYNC_BOTH             2'h3

// ==================================================================
// Reset values
`define DMASC_CTRL_RESET            32'h00000000
`define DMASC_WORD_RESET            32'h00000000

`endif

// *** design/dmasc_pkg.sv ***
// Types shared by the synchronised DMA channel.
package dmasc_pkg;

    typedef enum logic [1:0] {
        DMASC_HALT,
        DMASC_READ,
        DMASC_WRITE
    } dmasc_state_t;

endpackage

// *** design/dmasc_event_gen.sv ***
// Serial event detection and pending-event latch for DMA pacing.
`timescale 1ns/1ps
`default_nettype none

module dmasc_event_gen (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic serial_rx_event,
    input  wire logic serial_tx_buffer_empty,
    input  wire logic rx_route_en,
    input  wire logic tx_route_en,
    input  wire logic consume,
    input  wire logic flush,
    output logic      serial_tx_event,
    output logic      event_pending
);

    logic tx_empty_d;
    logic raw_event;

    // ==================================================================
    // Transmit event fires once, when the buffer has just emptied into the shifter.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tx_empty_d <= 1'b1;
        end else begin
            tx_empty_d <= serial_tx_buffer_empty;
        end
    end

    assign serial_tx_event = serial_tx_buffer_empty & ~tx_empty_d;

    assign raw_event = (serial_rx_event & rx_route_en) | (serial_tx_event & tx_route_en);

    // ==================================================================
    // A new event wins over a simultaneous consume so that none is lost, but a flush
    // wins over both: an event that arrives while events are ignored must not pace a later access.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            event_pending <= 1'b0;
        end else if (flush) begin
            event_pending <= 1'b0;
        end else if (raw_event) begin
            event_pending <= 1'b1;
        end else if (consume) begin
            event_pending <= 1'b0;
        end
    end

endmodule // dmasc_event_gen

`default_nettype wire

// *** verif/dmasc_channel_asserts.sv ***
// Port-level checker for the synchronised DMA channel.
`timescale 1ns/1ps
`default_nettype none

module dmasc_channel_asserts (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic [23:0] pbus_addr,
    input wire logic        pbus_wr,
    input wire logic        dma_req,
    input wire logic        dma_we,
    input wire logic [23:0] dma_addr,
    input wire logic        dma_shared_port,
    input wire logic        dma_ack,
    input wire logic        cpu_shared_port_busy,
    input wire logic        dma_done_flag,
    input wire logic        dma_irq_req
);
    logic last_we;
    logic wr_ack;
    assign wr_ack = dma_req && dma_ack && dma_we;
    // A control write restarts the sequence with a read, so the helper expects a read next.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            last_we <= 1'b1;
        end else if (pbus_wr && pbus_addr == 24'h808000) begin
            last_we <= 1'b1;
        end else if (dma_req && dma_ack) begin
            last_we <= dma_we;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence ack_s;
        dma_req && dma_ack;
    endsequence
    sequence wait_s;
        dma_req && !dma_ack && !pbus_wr && !$past(pbus_wr);
    endsequence
    // ==================================================================
    // Access handshake
    req_hold_a: assert property (wait_s |=> dma_req && $stable(dma_addr) && $stable(dma_we))
        else $error("dma request changed before ack");
    req_drop_a: assert property (ack_s |=> !dma_req)
        else $error("dma request held after ack");
    read_write_a: assert property ($rose(dma_req) |-> dma_we == !last_we)
        else $error("read and write do not alternate");
    // ==================================================================
    // Shared port and CPU priority
    shared_page_a: assert property (dma_req |-> dma_shared_port == (dma_addr[23:12] == 12'h808))
        else $error("shared port flag wrong");
    cpu_wins_a: assert property ($rose(dma_req) && dma_shared_port |-> !$past(cpu_shared_port_busy))
        else $error("dma took the shared port from the cpu");
    // ==================================================================
    // Completion signalling
    done_cause_a: assert property (dma_done_flag |-> $past(wr_ack, 1) || $past(wr_ack, 2))
        else $error("done pulse without a final write");
    done_pulse_a: assert property (dma_done_flag |=> !dma_done_flag)
        else $error("done flag longer than one cycle");
    irq_match_a: assert property (dma_irq_req == dma_done_flag)
        else $error("irq request and done flag differ");
endmodule // dmasc_channel_asserts

bind dmasc_channel dmasc_channel_asserts chk (
    .ref_clk(ref_clk), .rst(rst), .pbus_addr(pbus_addr), .pbus_wr(pbus_wr),
    .dma_req(dma_req), .dma_we(dma_we), .dma_addr(dma_addr), .dma_shared_port(dma_shared_port),
    .dma_ack(dma_ack), .cpu_shared_port_busy(cpu_shared_port_busy),
    .dma_done_flag(dma_done_flag), .dma_irq_req(dma_irq_req)
);

`default_nettype wire

// *** verif/dmasc_mem_model.sv ***
// Memory and serial register model answering the channel's access port.
`include "dmasc_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module dmasc_mem_model (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        dma_req,
    input  wire logic        dma_we,
    input  wire logic [23:0] dma_addr,
    input  wire logic [31:0] dma_wdata,
    input  wire logic [3:0]  wait_cyc,
    input  wire logic [31:0] rx_word,
    output logic             dma_ack,
    output logic      [31:0] dma_rdata,
    output logic      [31:0] tx_word
);
    logic [31:0] mem [256];
    logic [3:0]  cnt;
    initial for (int i = 0; i < 256; i++) mem[i] = 32'h5A000000 | i;
    // Read data is only meaningful with ack; otherwise it toggles so a stale capture shows.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dma_ack   <= 1'b0;
            cnt       <= 4'h0;
            dma_rdata <= 32'h0;
            tx_word   <= 32'h0;
        end else if (dma_req && dma_ack) begin
            dma_ack   <= 1'b0;
            cnt       <= 4'h0;
            dma_rdata <= ~dma_rdata;
            if (dma_we && dma_addr == `DMASC_SERIAL_TX_ADDR) tx_word <= dma_wdata;
            else if (dma_we) mem[dma_addr[7:0]] <= dma_wdata;
        end else if (dma_req && cnt >= wait_cyc) begin
            dma_ack   <= 1'b1;
            dma_rdata <= (dma_addr == `DMASC_SERIAL_RX_ADDR) ? rx_word : mem[dma_addr[7:0]];
        end else begin
            dma_ack   <= 1'b0;
            cnt       <= dma_req ? cnt + 4'h1 : 4'h0;
            dma_rdata <= ~dma_rdata;
        end
    end
endmodule // dmasc_mem_model

`default_nettype wire

// *** verif/tb_top.sv ***
// Self-checking testbench for the synchronised DMA channel.
`include "dmasc_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic        ref_clk = 0, rst = 1, pbus_wr = 0, pbus_rd = 0, busy = 0;
    logic        rxe = 0, txe = 0, rx_en = 0, tx_en = 0;
    logic [23:0] pbus_addr = 0;
    logic [31:0] pbus_wdata = 0, rx_word = 0;
    wire  [31:0] pbus_rdata, dma_wdata, dma_rdata, tx_word;
    wire  [23:0] dma_addr;
    wire         dma_req, dma_we, dma_sh, dma_ack, done, irq;
    int          err_total = 0, cmp_count = 0, n_done = 0;
    logic [31:0] q;
    localparam logic [23:0] G = `DMASC_GLOBAL_CONTROL_ADDR;

    always #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (done === 1'b1) n_done++;

    dmasc_channel dut (.ref_clk(ref_clk), .rst(rst), .pbus_addr(pbus_addr), .pbus_wr(pbus_wr),
        .pbus_rd(pbus_rd), .pbus_wdata(pbus_wdata), .pbus_rdata(pbus_rdata), .dma_req(dma_req),
        .dma_we(dma_we), .dma_addr(dma_addr), .dma_wdata(dma_wdata), .dma_shared_port(dma_sh),
        .dma_ack(dma_ack), .dma_rdata(dma_rdata), .cpu_shared_port_busy(busy),
        .serial_rx_event(rxe), .serial_tx_buffer_empty(txe), .rx_route_en(rx_en),
        .tx_route_en(tx_en), .dma_done_flag(done), .dma_irq_req(irq));
    dmasc_mem_model m (.ref_clk(ref_clk), .rst(rst), .dma_req(dma_req), .dma_we(dma_we),
        .dma_addr(dma_addr), .dma_wdata(dma_wdata), .wait_cyc(4'h2), .rx_word(rx_word),
        .dma_ack(dma_ack), .dma_rdata(dma_rdata), .tx_word(tx_word));

    // ==================================================================
    // Bus tasks and checks
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [23:0] a, input logic [31:0] d);
        tick(1); pbus_addr = a; pbus_wdata = d; pbus_wr = 1; tick(1); pbus_wr = 0;
    endtask
    task automatic rd(input logic [23:0] a);
        tick(1); pbus_addr = a; pbus_rd = 1; tick(1); pbus_rd = 0; tick(1); q = pbus_rdata;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic rchk(input string s, input logic [23:0] a, input logic [31:0] e);
        rd(a); chk(s, e, q);
    endtask
    task automatic setup(input logic [31:0] s, input logic [31:0] d, input logic [31:0] c);
        wr(G + `DMASC_SRC_OFFSET, s); wr(G + `DMASC_DST_OFFSET, d); wr(G + `DMASC_COUNT_OFFSET, c);
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic wait_done(input int n0);
        int i;
        for (i = 0; i < 400 && n_done == n0; i++) tick(1);
        if (n_done == n0) begin
            err_total++;
            $display("mismatch done_wait expected pulse seen none");
            complete_run;
        end
    endtask
    task automatic rx_ev(input logic [31:0] w);
        rx_word = w; rxe = 1; tick(1); rxe = 0; tick(15);
    endtask
    task automatic tx_ev;
        txe = 0; tick(2); txe = 1; tick(15);
    endtask

    // ==================================================================
    // Main sequence
    initial begin
        tick(8); rst = 0;
        rchk("ctrl_reset", G, 32'h0);
        rchk("count_reset", G + `DMASC_COUNT_OFFSET, 32'h0);
        rchk("unmapped", 24'h808010, 32'h0);
        wr(G, 32'hFFFFF0F0); rchk("ctrl_bits", G, 32'h000000F0);
        chk("halted_no_req", 32'h0, {31'h0, dma_req});
        $display("test registers done");
        // Block move keeping order, with completion pulse.
        setup(32'h800010, 32'h800040, 32'h4); wr(G, 32'h00000C53); wait_done(0);
        for (int i = 0; i < 4; i++) chk("fwd_word", 32'h5A000010 | i, m.mem[8'h40 + i]);
        chk("done_count", 32'd1, n_done);
        rchk("count_zero", G + `DMASC_COUNT_OFFSET, 32'h0);
        rchk("stat_done", G, 32'h00000C50);
        rchk("src_step", G + `DMASC_SRC_OFFSET, 32'h800014);
        rchk("dst_step", G + `DMASC_DST_OFFSET, 32'h800044);
        $display("test block_forward done");
        // Reversed destination order.
        setup(32'h800020, 32'h800060, 32'h3); wr(G, 32'h00000C93); wait_done(1);
        for (int i = 0; i < 3; i++) chk("rev_word", 32'h5A000020 | i, m.mem[8'h60 - i]);
        rchk("dst_down", G + `DMASC_DST_OFFSET, 32'h80005D);
        $display("test block_reverse done");
        // Count-zero halt without the interrupt enable gives no pulse.
        setup(32'h800030, 32'h8000A0, 32'h1); wr(G, 32'h00000453); tick(40);
        chk("no_irq", 32'd2, n_done);
        rchk("stat_noirq", G, 32'h00000450);
        $display("test irq_disabled done");
        // Receive-paced move from the serial receive register, with the CPU holding the port.
        rx_en = 1;
        setup({8'h0, `DMASC_SERIAL_RX_ADDR}, 32'h800080, 32'h2); wr(G, 32'h00000D43); tick(20);
        rchk("rx_wait", G + `DMASC_COUNT_OFFSET, 32'h2);
        busy = 1; rx_ev(32'h11110001);
        rchk("cpu_wins", G + `DMASC_COUNT_OFFSET, 32'h2);
        busy = 0; tick(10); rx_ev(32'h11110002); wait_done(2);
        chk("rx_word0", 32'h11110001, m.mem[8'h80]);
        chk("rx_word1", 32'h11110002, m.mem[8'h81]);
        rx_en = 0;
        $display("test rx_paced done");
        // Transmit-paced move: the write waits for the buffer to empty.
        tx_en = 1;
        // The buffer-empty edge lands on the read's completing edge and must be ignored.
        setup(32'h800090, {8'h0, `DMASC_SERIAL_TX_ADDR}, 32'h2); wr(G, 32'h00000E13); tick(5);
        txe = 1; tick(20);
        chk("tx_hold", 32'h0, tx_word);
        tx_ev;
        chk("tx_word0", 32'h5A000090, tx_word);
        tx_ev; wait_done(3);
        chk("tx_word1", 32'h5A000091, tx_word);
        $display("test tx_paced done");
        // Continuous loop back paced both ways, never ending at zero count.
        rx_en = 1;
        setup({8'h0, `DMASC_SERIAL_RX_ADDR}, {8'h0, `DMASC_SERIAL_TX_ADDR}, 32'h0); wr(G, 32'h00000303);
        for (int i = 0; i < 6; i++) rx_ev(32'h22220000 | i);
        chk("loop_tx", 32'h22220004, tx_word);
        rchk("loop_count", G + `DMASC_COUNT_OFFSET, 32'hFFFFFFFD);
        chk("loop_no_done", 32'd4, n_done);
        rchk("loop_run", G, 32'h0000030F);
        wr(G, 32'h0); tick(3); rchk("halted", G, 32'h0);
        $display("test loop_back done");
        complete_run;
    end
endmodule // tb_top

`default_nettype wire
